// >>> rdc_counter.sv
/*
 * Drift-corrected 16-bit real-time counter with an Avalon-MM slave.
 * Holds the registers, the byte latch for 16-bit access, the write
 * crossing with its busy flag, the counter, match logic, flags,
 * interrupt level outputs and thinned event pulses.
 * Assumes rtc_clk_in is a slow level synchronous to clk, and that the
 * bus master holds each request until waitrequest is seen low.
 */
// Contract
// - Prescale code 000 stops counting; others divide by 1,2,8,16,64,256,1024.
// - Setting correction_enable starts drift correction using drift_trim direction and size.
// - Clearing correction_enable stops correction only after the current interval ends.
// - Corrections repeat over an interval of about one million counter-clock cycles.
// - Each correction adds or drops one cycle; skew_count corrections per interval.
// - Direction 0 slows by dropping cycles; direction 1 speeds up by adding them.
// - Corrections appear in the tick_count value read back by software.
// - sync_pending_flag is high while a control/count/limit/match write crosses.
// - Count, limit and match updates take effect two counter-clock cycles later.
// - compare_irq_level enables and levels the compare request while its flag is set.
// - overflow_irq_level enables and levels the wrap request while wrap_flag is set.
// - compare_match_flag sets on the tick after a match; vector or write-one clears.
// - wrap_flag sets on the tick after a limit match; vector or write-one clears.
// - Low-byte write goes to byte_latch; low-byte read latches the high byte.
// - tick_count increments on each prescaled counter tick.
// - tick_count equal to wrap_limit sets wrap_flag and clears the count.
// - tick_count equal to match_value sets compare_match_flag.
// - No compare request or event when match_value exceeds wrap_limit.
// - Events every third match at limit zero, every second at one, else every.
`timescale 1ns/1ps
`default_nettype none
module rdc_counter
    import rdc_pkg::*;
#(
    parameter int unsigned CORR_INTERVAL = RDC_CORR_INTERVAL
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic rtc_clk_in,
    input wire logic compare_vector_ack,
    input wire logic wrap_vector_ack,
    output logic [1:0] compare_irq,
    output logic [1:0] wrap_irq,
    output logic compare_event,
    output logic wrap_event
);
    logic [7:0] control_setup;
    logic [7:0] control_live;
    logic [7:0] irq_setup;
    logic [1:0] irq_flags;
    logic [7:0] byte_latch;
    logic [7:0] drift_trim;
    logic [15:0] tick_count;
    logic [15:0] wrap_limit;
    logic [15:0] match_value;
    logic sync_pending_flag;
    logic [1:0] sync_edges;
    rdc_target_type pend_target;
    logic [15:0] pend_value;
    logic rtc_prev;
    logic [1:0] wrap_ev_count;
    logic [1:0] cmp_ev_count;

    logic rtc_edge;
    logic count_tick;
    logic correcting;
    logic [3:0] idx;
    logic acc_wr;
    logic acc_rd;
    logic wr_en;
    logic [7:0] wbyte;
    logic start_sync;
    rdc_target_type next_target;
    logic [15:0] next_value;
    logic sync_apply;
    logic wrap_hit;
    logic cmp_hit;
    logic [1:0] ev_modulus;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [7:0] read_byte;

    assign idx = address[5:2];
    assign acc_wr = write && !waitrequest;
    // Read taken in its first cycle, with readdata, so the latch is atomic
    assign acc_rd = read && waitrequest;
    assign wr_en = acc_wr && byteenable[0];
    assign wbyte = writedata[7:0];
    assign rtc_edge = rtc_clk_in && !rtc_prev;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rtc_prev <= 1'b0;
        end else begin
            rtc_prev <= rtc_clk_in;
        end
    end

    // Avalon slave: one wait cycle, then the answer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    // High byte reads return the byte captured by the low-byte read
    always_comb begin
        unique case (idx)
            RDC_IDX_CONTROL: read_byte = control_setup;
            RDC_IDX_SYNC: read_byte = {7'h00, sync_pending_flag};
            RDC_IDX_IRQ_SETUP: read_byte = irq_setup;
            RDC_IDX_IRQ_FLAGS: read_byte = {6'h00, irq_flags};
            RDC_IDX_LATCH: read_byte = byte_latch;
            RDC_IDX_TRIM: read_byte = drift_trim;
            RDC_IDX_COUNT_LOW: read_byte = tick_count[7:0];
            RDC_IDX_LIMIT_LOW: read_byte = wrap_limit[7:0];
            RDC_IDX_MATCH_LOW: read_byte = match_value[7:0];
            RDC_IDX_COUNT_HIGH, RDC_IDX_LIMIT_HIGH, RDC_IDX_MATCH_HIGH: read_byte = byte_latch;
            default: read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= {24'h00_0000, read_byte};
        end
    end

    // Byte latch for atomic 16-bit access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            byte_latch <= RDC_RESET_BYTE;
        end else if (wr_en && (idx == RDC_IDX_LATCH || idx == RDC_IDX_COUNT_LOW
                || idx == RDC_IDX_LIMIT_LOW || idx == RDC_IDX_MATCH_LOW)) begin
            byte_latch <= wbyte;
        end else if (acc_rd) begin
            unique case (idx)
                RDC_IDX_COUNT_LOW: byte_latch <= tick_count[15:8];
                RDC_IDX_LIMIT_LOW: byte_latch <= wrap_limit[15:8];
                RDC_IDX_MATCH_LOW: byte_latch <= match_value[15:8];
                default: byte_latch <= byte_latch;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            control_setup <= RDC_RESET_BYTE;
            irq_setup <= RDC_RESET_BYTE;
            drift_trim <= RDC_RESET_BYTE;
        end else if (wr_en) begin
            if (idx == RDC_IDX_CONTROL) begin
                control_setup <= wbyte & RDC_CTRL_MASK;
            end
            if (idx == RDC_IDX_IRQ_SETUP) begin
                irq_setup <= wbyte & RDC_IRQ_SETUP_MASK;
            end
            if (idx == RDC_IDX_TRIM) begin
                drift_trim <= wbyte;
            end
        end
    end

    // Writes that must cross into the counter-clock timing
    always_comb begin
        start_sync = 1'b0;
        next_target = RDC_TGT_CONTROL;
        next_value = {8'h00, wbyte & RDC_CTRL_MASK};
        if (wr_en) begin
            unique case (idx)
                RDC_IDX_CONTROL: begin
                    start_sync = 1'b1;
                end
                RDC_IDX_COUNT_HIGH: begin
                    start_sync = 1'b1;
                    next_target = RDC_TGT_COUNT;
                    next_value = {wbyte, byte_latch};
                end
                RDC_IDX_LIMIT_HIGH: begin
                    start_sync = 1'b1;
                    next_target = RDC_TGT_LIMIT;
                    next_value = {wbyte, byte_latch};
                end
                RDC_IDX_MATCH_HIGH: begin
                    start_sync = 1'b1;
                    next_target = RDC_TGT_MATCH;
                    next_value = {wbyte, byte_latch};
                end
                default: start_sync = 1'b0;
            endcase
        end
    end

    assign sync_apply = sync_pending_flag && rtc_edge && !start_sync
        && (sync_edges == RDC_SYNC_EDGES - 2'h1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_pending_flag <= 1'b0;
            sync_edges <= 2'h0;
            pend_target <= RDC_TGT_CONTROL;
            pend_value <= RDC_RESET_WORD;
        end else if (start_sync) begin
            sync_pending_flag <= 1'b1;
            sync_edges <= 2'h0;
            pend_target <= next_target;
            pend_value <= next_value;
        end else if (sync_apply) begin
            sync_pending_flag <= 1'b0;
            sync_edges <= 2'h0;
        end else if (sync_pending_flag && rtc_edge) begin
            sync_edges <= sync_edges + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            control_live <= RDC_RESET_BYTE;
            wrap_limit <= RDC_RESET_WORD;
            match_value <= RDC_RESET_WORD;
        end else if (sync_apply) begin
            if (pend_target == RDC_TGT_CONTROL) begin
                control_live <= pend_value[7:0];
            end
            if (pend_target == RDC_TGT_LIMIT) begin
                wrap_limit <= pend_value;
            end
            if (pend_target == RDC_TGT_MATCH) begin
                match_value <= pend_value;
            end
        end
    end

    rdc_prescaler #(
        .INTERVAL(CORR_INTERVAL)
    ) u_prescaler (
        .clk(clk),
        .arst_n(arst_n),
        .rtc_edge(rtc_edge),
        .prescale_select(control_live[2:0]),
        .correction_enable(control_live[RDC_CTRL_CORR_BIT]),
        .correction_direction(drift_trim[RDC_TRIM_DIR_BIT]),
        .skew_count(drift_trim[6:0]),
        .count_tick(count_tick),
        .correcting(correcting)
    );

    assign wrap_hit = count_tick && (tick_count == wrap_limit);
    assign cmp_hit = count_tick && (tick_count == match_value)
        && (match_value <= wrap_limit);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_count <= RDC_RESET_WORD;
        end else if (sync_apply && pend_target == RDC_TGT_COUNT) begin
            tick_count <= pend_value;
        end else if (wrap_hit) begin
            tick_count <= RDC_RESET_WORD;
        end else if (count_tick) begin
            tick_count <= tick_count + 16'h0001;
        end
    end

    // Flags: a set in the same cycle as a clear wins
    assign flag_set = {cmp_hit, wrap_hit};
    assign flag_clr = {compare_vector_ack, wrap_vector_ack}
        | ((wr_en && idx == RDC_IDX_IRQ_FLAGS) ? wbyte[1:0] : 2'h0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_flags <= 2'h0;
        end else begin
            irq_flags <= (irq_flags & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            compare_irq <= 2'h0;
            wrap_irq <= 2'h0;
        end else begin
            compare_irq <= irq_flags[RDC_FLAG_COMPARE_BIT] ? irq_setup[3:2] : 2'h0;
            wrap_irq <= irq_flags[RDC_FLAG_WRAP_BIT] ? irq_setup[1:0] : 2'h0;
        end
    end

    // Event thinning for very short periods
    assign ev_modulus = (wrap_limit == 16'h0000) ? 2'h2
        : (wrap_limit == 16'h0001) ? 2'h1 : 2'h0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrap_ev_count <= 2'h0;
            cmp_ev_count <= 2'h0;
            wrap_event <= 1'b0;
            compare_event <= 1'b0;
        end else begin
            wrap_event <= wrap_hit && (wrap_ev_count == 2'h0);
            compare_event <= cmp_hit && (cmp_ev_count == 2'h0);
            if (wrap_hit) begin
                wrap_ev_count <= (wrap_ev_count >= ev_modulus) ? 2'h0 : wrap_ev_count + 2'h1;
            end
            if (cmp_hit) begin
                cmp_ev_count <= (cmp_ev_count >= ev_modulus) ? 2'h0 : cmp_ev_count + 2'h1;
            end
        end
    end

    sequence s_bus_request;
        (read || write) && waitrequest;
    endsequence

    sequence s_bus_answer;
        !waitrequest ##1 waitrequest;
    endsequence

    AST_BUS_ONE_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
        s_bus_request |=> s_bus_answer)
        else $error("bus answer not after one wait cycle");

    AST_SYNC_RAISED: assert property (@(posedge clk) disable iff (!arst_n)
        start_sync |=> sync_pending_flag)
        else $error("busy flag not raised by a crossing write");

    AST_SYNC_TWO_EDGES: assert property (@(posedge clk) disable iff (!arst_n)
        (sync_pending_flag && !rtc_edge)
        |=> sync_pending_flag)
        else $error("crossing ended without counter-clock edges");

    AST_LIMIT_APPLIED: assert property (@(posedge clk) disable iff (!arst_n)
        (sync_apply && pend_target == RDC_TGT_LIMIT)
        |=> (wrap_limit == $past(pend_value)) && !sync_pending_flag)
        else $error("limit not applied at end of crossing");

    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!arst_n)
        (count_tick && !wrap_hit && !sync_apply) |=> tick_count == $past(tick_count) + 16'h0001)
        else $error("count did not step on tick");

    AST_WRAP_CLEARS: assert property (@(posedge clk) disable iff (!arst_n)
        (wrap_hit && !sync_apply) |=> (tick_count == 16'h0000) && irq_flags[RDC_FLAG_WRAP_BIT])
        else $error("limit match did not clear count and set flag");

    AST_NO_COMPARE_ABOVE: assert property (@(posedge clk) disable iff (!arst_n)
        (match_value > wrap_limit && $stable(match_value) && $stable(wrap_limit))
        |=> !compare_event && !irq_flags[RDC_FLAG_COMPARE_BIT] || $past(irq_flags[1]))
        else $error("compare raised with match above limit");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> compare_irq == ($past(irq_flags[1]) ? $past(irq_setup[3:2]) : 2'h0)
        && wrap_irq == ($past(irq_flags[0]) ? $past(irq_setup[1:0]) : 2'h0))
        else $error("interrupt level output wrong");

    AST_LATCH_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
        (acc_rd && idx == RDC_IDX_COUNT_LOW) |=> byte_latch == $past(tick_count[15:8]))
        else $error("low read did not latch high byte");

    AST_EVENT_THIRD: assert property (@(posedge clk) disable iff (!arst_n)
        (wrap_limit == 16'h0000 && wrap_event) |=> !wrap_event ##1 !wrap_event)
        else $error("events too dense at limit zero");

endmodule
`default_nettype wire

// >>> rdc_pkg.sv
/*
 * Shared constants for the drift-corrected real-time counter: register
 * indices, field positions, reset values and crossing figures.
 * Assumes byte-wide registers, each in the low byte of one aligned 32-bit word.
 */
package rdc_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [3:0] RDC_IDX_CONTROL = 4'h0;
    localparam logic [3:0] RDC_IDX_SYNC = 4'h1;
    localparam logic [3:0] RDC_IDX_IRQ_SETUP = 4'h2;
    localparam logic [3:0] RDC_IDX_IRQ_FLAGS = 4'h3;
    localparam logic [3:0] RDC_IDX_LATCH = 4'h4;
    localparam logic [3:0] RDC_IDX_TRIM = 4'h6;
    localparam logic [3:0] RDC_IDX_COUNT_LOW = 4'h8;
    localparam logic [3:0] RDC_IDX_COUNT_HIGH = 4'h9;
    localparam logic [3:0] RDC_IDX_LIMIT_LOW = 4'ha;
    localparam logic [3:0] RDC_IDX_LIMIT_HIGH = 4'hb;
    localparam logic [3:0] RDC_IDX_MATCH_LOW = 4'hc;
    localparam logic [3:0] RDC_IDX_MATCH_HIGH = 4'hd;

    // Field positions
    localparam int RDC_CTRL_CORR_BIT = 3;
    localparam logic [7:0] RDC_CTRL_MASK = 8'h0f;
    localparam logic [7:0] RDC_IRQ_SETUP_MASK = 8'h0f;
    localparam int RDC_FLAG_COMPARE_BIT = 1;
    localparam int RDC_FLAG_WRAP_BIT = 0;
    localparam int RDC_TRIM_DIR_BIT = 7;

    localparam logic [7:0] RDC_RESET_BYTE = 8'h00;
    localparam logic [15:0] RDC_RESET_WORD = 16'h0000;

    // Counter-clock edges from register write to effect
    localparam logic [1:0] RDC_SYNC_EDGES = 2'h2;
    // Correction interval in counter-clock cycles
    localparam int unsigned RDC_CORR_INTERVAL = 1000000;

    typedef enum logic [1:0] {
        RDC_TGT_CONTROL,
        RDC_TGT_COUNT,
        RDC_TGT_LIMIT,
        RDC_TGT_MATCH
    } rdc_target_type;

    // Last value of the prescaler counter for each select code
    function automatic logic [9:0] rdc_div_last(input logic [2:0] sel);
        unique case (sel)
            3'h1: rdc_div_last = 10'h000;
            3'h2: rdc_div_last = 10'h001;
            3'h3: rdc_div_last = 10'h007;
            3'h4: rdc_div_last = 10'h00f;
            3'h5: rdc_div_last = 10'h03f;
            3'h6: rdc_div_last = 10'h0ff;
            3'h7: rdc_div_last = 10'h3ff;
            default: rdc_div_last = 10'h000;
        endcase
    endfunction

endpackage

// >>> rdc_prescaler.sv
/*
 * Drift correction and prescaler. Takes one pulse per counter-clock edge,
 * drops or adds single cycles spread over the correction interval, then
 * divides by the selected factor and gives one tick pulse per count.
 * Assumes counter-clock edges are at least two system cycles apart.
 */
`timescale 1ns/1ps
`default_nettype none
module rdc_prescaler
    import rdc_pkg::*;
#(
    parameter int unsigned INTERVAL = RDC_CORR_INTERVAL
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic rtc_edge,
    input wire logic [2:0] prescale_select,
    input wire logic correction_enable,
    input wire logic correction_direction,
    input wire logic [6:0] skew_count,
    output logic count_tick,
    output logic correcting
);
    localparam int AW = $clog2(INTERVAL) + 1;
    localparam logic [AW-1:0] LAST = AW'(INTERVAL - 1);
    localparam logic [AW-1:0] SPAN = AW'(INTERVAL);

    if (INTERVAL < 128 || INTERVAL > 16777216) begin : g_bad_interval
        $error("INTERVAL must lie in 128..16777216");
    end

    logic [AW-1:0] phase;
    logic [AW-1:0] spread;
    logic extra_pending;
    logic [9:0] div_count;
    logic [AW-1:0] spread_sum;
    logic corr_hit;
    logic interval_end;
    logic src_pulse;

    // Even spacing: a correction at each wrap of the spread accumulator
    assign spread_sum = spread + AW'(skew_count);
    assign corr_hit = correcting && rtc_edge && (spread_sum >= SPAN);
    assign interval_end = correcting && rtc_edge && (phase == LAST);
    // Slow: drop the edge; fast: add a second pulse one cycle later
    assign src_pulse = (rtc_edge && !(corr_hit && !correction_direction))
        || extra_pending;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            correcting <= 1'b0;
            phase <= '0;
            spread <= '0;
        end else if (!correcting) begin
            if (correction_enable) begin
                correcting <= 1'b1;
                phase <= '0;
                spread <= '0;
            end
        end else if (interval_end) begin
            correcting <= correction_enable;
            phase <= '0;
            spread <= '0;
        end else if (rtc_edge) begin
            phase <= phase + 1'b1;
            spread <= corr_hit ? spread_sum - SPAN : spread_sum;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extra_pending <= 1'b0;
        end else begin
            extra_pending <= corr_hit && correction_direction;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_count <= '0;
            count_tick <= 1'b0;
        end else if (prescale_select == 3'h0) begin
            div_count <= '0;
            count_tick <= 1'b0;
        end else if (src_pulse) begin
            if (div_count >= rdc_div_last(prescale_select)) begin
                div_count <= '0;
                count_tick <= 1'b1;
            end else begin
                div_count <= div_count + 1'b1;
                count_tick <= 1'b0;
            end
        end else begin
            count_tick <= 1'b0;
        end
    end

    AST_STOPPED_NO_TICK: assert property (@(posedge clk) disable iff (!arst_n)
        prescale_select == 3'h0 |=> !count_tick)
        else $error("tick while prescaler is off");

    AST_DIV1_EVERY_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
        (prescale_select == 3'h1 && rtc_edge && !correcting) |=> count_tick)
        else $error("divide-by-one missed an edge");

    AST_KEEP_TO_END: assert property (@(posedge clk) disable iff (!arst_n)
        (correcting && !interval_end) |=> correcting)
        else $error("correction stopped before interval end");

    AST_FAST_ADDS: assert property (@(posedge clk) disable iff (!arst_n)
        (corr_hit && correction_direction) |=> extra_pending ##1 !extra_pending)
        else $error("speed-up did not add exactly one pulse");

endmodule
`default_nettype wire

// >>> tb_rdc_counter.sv
/*
 * Self-checking bench for rdc_counter: register reset, write crossing,
 * prescaler codes, wrap and compare flags with their interrupt levels.
 * Assumes the design's own assertions; counter clock is a slow level.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_rdc_counter;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'hf;
    logic rtc_clk_in = 1'b0;
    logic compare_vector_ack = 1'b0;
    logic wrap_vector_ack = 1'b0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] compare_irq;
    logic [1:0] wrap_irq;
    logic compare_event;
    logic wrap_event;
    logic [7:0] q;
    int fails = 0;
    int total_checks = 0;
    int div[8] = '{0, 1, 2, 8, 16, 64, 256, 1024};
    int wrap_evs = 0;
    int cmp_evs = 0;

    always #10 clk = ~clk;

    // Event pulse counters
    always @(posedge clk) begin
        if (wrap_event === 1'b1) wrap_evs++;
        if (compare_event === 1'b1) cmp_evs++;
    end

    rdc_counter #(.CORR_INTERVAL(200)) dut (.clk(clk), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .rtc_clk_in(rtc_clk_in),
        .compare_vector_ack(compare_vector_ack), .wrap_vector_ack(wrap_vector_ack),
        .compare_irq(compare_irq), .wrap_irq(wrap_irq), .compare_event(compare_event),
        .wrap_event(wrap_event));

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        int n;
        n = 0;
        address <= a;
        write <= we;
        read <= !we;
        writedata <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fails++;
            final_report();
        end
        r = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        check({8'h00, r}, {8'h00, exp});
    endtask

    task automatic rd16(input logic [5:0] a, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        bus(1'b0, a, 8'h00, lo);
        bus(1'b0, a + 6'h04, 8'h00, hi);
        v = {hi, lo};
    endtask

    task automatic edges(input int n);
        repeat (n) begin
            rtc_clk_in <= 1'b1;
            repeat (3) @(posedge clk);
            rtc_clk_in <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // Crossing write after checking the flag reads clear, then two counter edges apply it
    task automatic wrx(input logic [5:0] a, input logic [7:0] d);
        rd_chk(6'h04, 8'h00);
        bus(1'b1, a, d, q);
        edges(2);
    endtask

    task automatic ack(input logic cmp);
        if (cmp) compare_vector_ack <= 1'b1;
        else wrap_vector_ack <= 1'b1;
        @(posedge clk);
        compare_vector_ack <= 1'b0;
        wrap_vector_ack <= 1'b0;
        @(posedge clk);
    endtask

    task automatic test_reset();
        for (int i = 0; i < 14; i++) begin
            rd_chk({i[3:0], 2'b00}, 8'h00);
        end
    endtask

    task automatic test_sync_prescale();
        logic [15:0] c0;
        logic [15:0] c1;
        bus(1'b1, 6'h28, 8'hff, q);
        bus(1'b1, 6'h2c, 8'hff, q);
        rd_chk(6'h04, 8'h01);
        edges(1);
        rd_chk(6'h04, 8'h01);
        edges(1);
        rd_chk(6'h04, 8'h00);
        for (int code = 0; code < 8; code++) begin
            wrx(6'h00, {5'h00, code[2:0]});
            rd16(6'h20, c0);
            edges(code == 0 ? 4 : 2 * div[code]);
            rd16(6'h20, c1);
            check(c1 - c0, code == 0 ? 16'h0000 : 16'h0002);
        end
    endtask

    task automatic test_wrap_compare();
        logic [15:0] c;
        int k;
        wrx(6'h00, 8'h00);
        bus(1'b1, 6'h20, 8'h00, q);
        wrx(6'h24, 8'h00);
        bus(1'b1, 6'h28, 8'h03, q);
        wrx(6'h2c, 8'h00);
        bus(1'b1, 6'h30, 8'h02, q);
        wrx(6'h34, 8'h00);
        bus(1'b1, 6'h08, 8'h0e, q);
        wrx(6'h00, 8'h01);
        bus(1'b1, 6'h0c, 8'h03, q);
        k = 0;
        q = 8'h00;
        while (q[0] !== 1'b1 && k < 12) begin
            edges(1);
            bus(1'b0, 6'h0c, 8'h00, q);
            k++;
        end
        check({15'h0000, q[0]}, 16'h0001);
        bus(1'b1, 6'h0c, 8'h03, q);
        edges(4);
        rd_chk(6'h0c, 8'h03);
        check({14'h0000, compare_irq}, 16'h0003);
        check({14'h0000, wrap_irq}, 16'h0002);
        rd16(6'h20, c);
        check(c, 16'h0000);
        bus(1'b1, 6'h0c, 8'h01, q);
        rd_chk(6'h0c, 8'h02);
        ack(1'b1);
        rd_chk(6'h0c, 8'h00);
    endtask

    task automatic test_match_above_limit();
        int m0;
        bus(1'b1, 6'h30, 8'h05, q);
        wrx(6'h34, 8'h00);
        bus(1'b1, 6'h0c, 8'h03, q);
        m0 = cmp_evs;
        edges(8);
        rd_chk(6'h0c, 8'h01);
        check({14'h0000, compare_irq}, 16'h0000);
        check(16'(cmp_evs - m0), 16'h0000);
        ack(1'b0);
        rd_chk(6'h0c, 8'h00);
    endtask

    // Stopped counter at zero, limit and match zero: every tick matches
    task automatic test_events();
        int w0;
        int m0;
        wrx(6'h00, 8'h00);
        bus(1'b1, 6'h20, 8'h00, q);
        wrx(6'h24, 8'h00);
        bus(1'b1, 6'h28, 8'h00, q);
        wrx(6'h2c, 8'h00);
        bus(1'b1, 6'h30, 8'h00, q);
        wrx(6'h34, 8'h00);
        wrx(6'h00, 8'h01);
        w0 = wrap_evs;
        m0 = cmp_evs;
        edges(9);
        check(16'(wrap_evs - w0), 16'h0003);
        check(16'(cmp_evs - m0), 16'h0003);
    endtask

    // Skew 127 over a 200-edge interval: 127 corrections per interval
    task automatic test_correction();
        logic [15:0] c0;
        logic [15:0] c1;
        bus(1'b1, 6'h28, 8'hff, q);
        wrx(6'h2c, 8'hff);
        wrx(6'h00, 8'h00);
        bus(1'b1, 6'h18, 8'hff, q);
        wrx(6'h00, 8'h0a);
        rd16(6'h20, c0);
        edges(200);
        rd16(6'h20, c1);
        check(c1 - c0, 16'h00a3);
        bus(1'b1, 6'h18, 8'h7f, q);
        wrx(6'h00, 8'h09);
        rd16(6'h20, c0);
        edges(200);
        rd16(6'h20, c1);
        check(c1 - c0, 16'h0049);
        wrx(6'h00, 8'h01);
        rd16(6'h20, c0);
        edges(8);
        rd16(6'h20, c1);
        check(c1 - c0, 16'h0003);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        test_reset();
        test_sync_prescale();
        test_wrap_compare();
        test_match_above_limit();
        test_events();
        test_correction();
        final_report();
    end
endmodule
`default_nettype wire
